// ### inc/pio_defines.svh
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define PIO_NUM_PINS 32
`define PIO_HALF_W 16
`define PIO_ADDR_W 12

// ----------------------------------------------------------------
// register offsets in the configuration region
// ----------------------------------------------------------------
`define PIO_OFF_FS_LO 12'hC20
`define PIO_OFF_FS_HI 12'hC22
`define PIO_OFF_DIR_LO 12'hC2A
`define PIO_OFF_DIR_HI 12'hC2C
`define PIO_OFF_LVL_LO 12'hC30
`define PIO_OFF_LVL_HI 12'hC32
`define PIO_OFF_SET_LO 12'hC34
`define PIO_OFF_SET_HI 12'hC36
`define PIO_OFF_CLR_LO 12'hC38
`define PIO_OFF_CLR_HI 12'hC3A
`define PIO_HALF_STEP 12'h002

// ----------------------------------------------------------------
// reset values and fixed routing
// ----------------------------------------------------------------
`define PIO_RST_HALF 16'h0000
`define PIO_RST_WORD 32'h0000_0000
// low-half pins whose interface signal is an output of the chip
`define PIO_ALT_DRIVE_LO 16'h1E1B

`endif

// ### inc/pio_pkg.sv
`default_nettype none

package pio_pkg;

   // register request from the configuration region
   typedef struct packed
   {
      logic wr;
      logic size32;
      logic [11:0] addr;
      logic [31:0] wdata;
   } pio_req_t;

   // per-pin write strobes plus the written bit
   typedef struct packed
   {
      logic fs;
      logic dir;
      logic data;
      logic set;
      logic clr;
      logic val;
   } pio_cell_wr_t;

   typedef enum logic [1:0]
   {
      PIO_ST_IDLE = 2'b01,
      PIO_ST_HIGH = 2'b10
   } pio_state_t;

endpackage

`default_nettype wire

// ### core/pio_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module pio_pin_cell
(
   input wire logic core_clk,
   input wire logic srst,
   input wire pio_pkg::pio_cell_wr_t wr,
   input wire logic alt_out,
   input wire logic alt_oe,
   output logic fs,
   output logic dir,
   output logic pin_out,
   output logic pin_oe
);

   logic level;
   logic next_fs;
   logic next_dir;
   logic next_level;
   logic next_pin_out;
   logic next_pin_oe;

   // ----------------------------------------------------------------
   // pin control
   // ----------------------------------------------------------------
   always_comb
   begin
      next_fs = fs;
      next_dir = dir;
      next_level = level;
      if (wr.fs)
      begin
         next_fs = wr.val;
      end
      if (!fs)
      begin
         if (wr.dir)
         begin
            next_dir = wr.val;
         end
         if (dir)
         begin
            // data, set and clear share one output level
            if (wr.data)
            begin
               next_level = wr.val;
            end
            if (wr.set && wr.val)
            begin
               next_level = 1'b1;
            end
            if (wr.clr && wr.val)
            begin
               next_level = 1'b0;
            end
         end
      end
      next_pin_out = next_fs ? alt_out : next_level;
      next_pin_oe = next_fs ? alt_oe : next_dir;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         // input, pull-up or pull-down terminates the pin
         fs <= 1'b0;
         dir <= 1'b0;
         level <= 1'b0;
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end
      else
      begin
         fs <= next_fs;
         dir <= next_dir;
         level <= next_level;
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
      end
   end

endmodule

`default_nettype wire

// ### core/pio_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "pio_defines.svh"

// Function
// - each of the 32 pins has a select bit, 1 gives its interface signal, 0 gives I/O.
// - with select at 1, writes to direction, data, set and clear are ignored; data still reads the pin.
// - with select 0 and direction 0 the pin is an input and data, set, clear writes do nothing.
// - on an output, a 1 written to the clear bit drives the pin low.
// - on an output, a 1 written to the set bit drives the pin high.
// - on an output, writing 0 or 1 to the data bit drives the pin low or high.
// - a read of a data bit always returns the real pin level in every mode.
// - data, set and clear act on one shared output level, so software should use only one.
// - after reset every select bit is 0 and every pin is an undriven input.
// - low select bits 15-13 route to interrupt inputs 8-10, bits 12-9 to DMA acknowledges 0-3.
// - bits 8-5 route to DMA requests 0-3, bits 4-0 to count, address enable, ready, byte high, latch.
// - the control set is ten registers, each of the five controls split in two halves.
// - a 32-bit access is done as two 16-bit accesses, low half first, then high half.

module pio_port
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic req_valid,
   input wire pio_pkg::pio_req_t req,
   output logic req_ack,
   output logic req_busy,
   output logic [31:0] req_rdata,
   input wire logic [31:0] pin_in,
   output logic [31:0] pin_out,
   output logic [31:0] pin_oe,
   input wire logic [3:0] bus_dma_acknowledge,
   input wire logic bus_terminal_count,
   input wire logic bus_address_enable,
   input wire logic bus_byte_high_enable,
   input wire logic bus_address_latch_enable,
   output logic [10:8] bus_interrupt_input,
   output logic [3:0] bus_dma_request,
   output logic bus_ready_input,
   input wire logic [15:0] hi_func_out,
   input wire logic [15:0] hi_func_oe,
   output logic [15:0] hi_func_in
);

   pio_pkg::pio_state_t state;
   pio_pkg::pio_state_t next_state;
   pio_pkg::pio_req_t hold;
   pio_pkg::pio_req_t next_hold;
   logic next_ack;
   logic next_busy;
   logic [31:0] next_rdata;

   logic op_go;
   logic op_wr;
   logic [11:0] op_addr;
   logic [15:0] op_data;
   logic op_write;
   logic [15:0] rd16;

   logic [31:0] fs_v;
   logic [31:0] dir_v;
   logic [31:0] we_fs;
   logic [31:0] we_dir;
   logic [31:0] we_lvl;
   logic [31:0] we_set;
   logic [31:0] we_clr;
   logic [31:0] wbits;
   logic [31:0] alt_out;
   logic [31:0] alt_oe;

   logic [10:8] next_irq;
   logic [3:0] next_drq;
   logic next_rdy;
   logic [15:0] next_hi_in;

   // ----------------------------------------------------------------
   // access sequencing
   // ----------------------------------------------------------------
   // a 32-bit request becomes two half accesses on consecutive cycles
   always_comb
   begin
      op_go = 1'b0;
      op_wr = req.wr;
      op_addr = req.addr;
      op_data = req.wdata[15:0];
      case (state)
         pio_pkg::PIO_ST_IDLE:
         begin
            op_go = req_valid;
         end
         pio_pkg::PIO_ST_HIGH:
         begin
            op_go = 1'b1;
            op_wr = hold.wr;
            op_addr = hold.addr + `PIO_HALF_STEP;
            op_data = hold.wdata[31:16];
         end
         default:
         begin
            op_go = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      next_state = state;
      next_hold = hold;
      next_ack = 1'b0;
      next_rdata = req_rdata;
      case (state)
         pio_pkg::PIO_ST_IDLE:
         begin
            if (req_valid)
            begin
               next_hold = req;
               next_rdata = {`PIO_RST_HALF, rd16};
               if (req.size32)
               begin
                  next_state = pio_pkg::PIO_ST_HIGH;
               end
               else
               begin
                  next_ack = 1'b1;
               end
            end
         end
         pio_pkg::PIO_ST_HIGH:
         begin
            // low half was done first, high half completes the word
            next_rdata = {rd16, req_rdata[15:0]};
            next_ack = 1'b1;
            next_state = pio_pkg::PIO_ST_IDLE;
         end
         default:
         begin
            next_state = pio_pkg::PIO_ST_IDLE;
         end
      endcase
      next_busy = (next_state == pio_pkg::PIO_ST_HIGH);
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         state <= pio_pkg::PIO_ST_IDLE;
         hold <= '0;
         req_ack <= 1'b0;
         req_busy <= 1'b0;
         req_rdata <= `PIO_RST_WORD;
      end
      else
      begin
         state <= next_state;
         hold <= next_hold;
         req_ack <= next_ack;
         req_busy <= next_busy;
         req_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   // set and clear are write-only and read as zero, as does any
   // offset outside the register set
   always_comb
   begin
      case (op_addr)
         `PIO_OFF_FS_LO:
         begin
            rd16 = fs_v[15:0];
         end
         `PIO_OFF_FS_HI:
         begin
            rd16 = fs_v[31:16];
         end
         `PIO_OFF_DIR_LO:
         begin
            rd16 = dir_v[15:0];
         end
         `PIO_OFF_DIR_HI:
         begin
            rd16 = dir_v[31:16];
         end
         `PIO_OFF_LVL_LO:
         begin
            rd16 = pin_in[15:0];
         end
         `PIO_OFF_LVL_HI:
         begin
            rd16 = pin_in[31:16];
         end
         default:
         begin
            rd16 = `PIO_RST_HALF;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   always_comb
   begin
      op_write = op_go && op_wr;
      we_fs = {{16{op_write && (op_addr == `PIO_OFF_FS_HI)}},
               {16{op_write && (op_addr == `PIO_OFF_FS_LO)}}};
      we_dir = {{16{op_write && (op_addr == `PIO_OFF_DIR_HI)}},
                {16{op_write && (op_addr == `PIO_OFF_DIR_LO)}}};
      we_lvl = {{16{op_write && (op_addr == `PIO_OFF_LVL_HI)}},
                {16{op_write && (op_addr == `PIO_OFF_LVL_LO)}}};
      we_set = {{16{op_write && (op_addr == `PIO_OFF_SET_HI)}},
                {16{op_write && (op_addr == `PIO_OFF_SET_LO)}}};
      we_clr = {{16{op_write && (op_addr == `PIO_OFF_CLR_HI)}},
                {16{op_write && (op_addr == `PIO_OFF_CLR_LO)}}};
      wbits = {op_data, op_data};
   end

   // ----------------------------------------------------------------
   // interface signal routing
   // ----------------------------------------------------------------
   always_comb
   begin
      alt_out = `PIO_RST_WORD;
      alt_out[12] = bus_dma_acknowledge[0];
      alt_out[11] = bus_dma_acknowledge[1];
      alt_out[10] = bus_dma_acknowledge[2];
      alt_out[9] = bus_dma_acknowledge[3];
      alt_out[4] = bus_terminal_count;
      alt_out[3] = bus_address_enable;
      alt_out[1] = bus_byte_high_enable;
      alt_out[0] = bus_address_latch_enable;
      alt_out[31:16] = hi_func_out;
      alt_oe = {hi_func_oe, `PIO_ALT_DRIVE_LO};
   end

   // inputs to the bus controller read zero while the pin is I/O
   always_comb
   begin
      next_irq[8] = fs_v[15] & pin_in[15];
      next_irq[9] = fs_v[14] & pin_in[14];
      next_irq[10] = fs_v[13] & pin_in[13];
      next_drq[0] = fs_v[8] & pin_in[8];
      next_drq[1] = fs_v[7] & pin_in[7];
      next_drq[2] = fs_v[6] & pin_in[6];
      next_drq[3] = fs_v[5] & pin_in[5];
      next_rdy = fs_v[2] & pin_in[2];
      next_hi_in = fs_v[31:16] & pin_in[31:16];
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         bus_interrupt_input <= 3'h0;
         bus_dma_request <= 4'h0;
         bus_ready_input <= 1'b0;
         hi_func_in <= `PIO_RST_HALF;
      end
      else
      begin
         bus_interrupt_input <= next_irq;
         bus_dma_request <= next_drq;
         bus_ready_input <= next_rdy;
         hi_func_in <= next_hi_in;
      end
   end

   // ----------------------------------------------------------------
   // pin cells
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `PIO_NUM_PINS; gi = gi + 1)
      begin : g_pin
         pio_pkg::pio_cell_wr_t cell_wr;

         always_comb
         begin
            cell_wr.fs = we_fs[gi];
            cell_wr.dir = we_dir[gi];
            cell_wr.data = we_lvl[gi];
            cell_wr.set = we_set[gi];
            cell_wr.clr = we_clr[gi];
            cell_wr.val = wbits[gi];
         end

         pio_pin_cell u_cell
         (
            .core_clk(core_clk),
            .srst(srst),
            .wr(cell_wr),
            .alt_out(alt_out[gi]),
            .alt_oe(alt_oe[gi]),
            .fs(fs_v[gi]),
            .dir(dir_v[gi]),
            .pin_out(pin_out[gi]),
            .pin_oe(pin_oe[gi])
         );
      end
   endgenerate

endmodule

`default_nettype wire

// ### testbench/pio_port_chk.sv
`timescale 1ns/1ps
`default_nettype none

module pio_port_chk
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic req_valid,
   input wire pio_pkg::pio_req_t req,
   input wire logic req_ack,
   input wire logic req_busy,
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [10:8] bus_interrupt_input,
   input wire logic [3:0] bus_dma_request,
   input wire logic bus_ready_input,
   input wire logic [15:0] hi_func_in
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   AST_ACK_HALF: assert property (req_valid && !req_busy && !req.size32
      |=> req_ack && !req_busy) else $error("half access not acked");
   AST_SPLIT: assert property (req_valid && !req_busy && req.size32
      |=> req_busy && !req_ack ##1 req_ack && !req_busy)
      else $error("word access not split in two");
   AST_BUSY_ONE: assert property (req_busy |=> !req_busy)
      else $error("busy longer than one cycle");
   AST_RST: assert property (disable iff (1'b0) srst
      |=> pin_oe == 32'h0 && !req_ack && !req_busy)
      else $error("pins driven after reset");
   AST_OE_CAUSE: assert property ($changed(pin_oe[15:0] & 16'hE1E4)
      |-> req_ack || req_busy) else $error("drive enable moved alone");
   AST_OUT_CAUSE: assert property ($changed(pin_out[15:0] & 16'hE1E4)
      |-> req_ack || req_busy) else $error("drive level moved alone");
   AST_IRQ_ROUTE: assert property ((bus_interrupt_input &
      ~$past({pin_in[13], pin_in[14], pin_in[15]})) == 3'h0)
      else $error("interrupt input not from its pin");
   AST_DRQ_ROUTE: assert property ((bus_dma_request &
      ~$past({pin_in[5], pin_in[6], pin_in[7], pin_in[8]})) == 4'h0)
      else $error("dma request not from its pin");
   AST_RDY_ROUTE: assert property (bus_ready_input |-> $past(pin_in[2]))
      else $error("ready not from its pin");
   AST_HI_IN: assert property ((hi_func_in & ~$past(pin_in[31:16]))
      == 16'h0) else $error("high interface input not from pin");
endmodule

bind pio_port pio_port_chk u_chk
(
   .core_clk, .srst, .req_valid, .req, .req_ack, .req_busy, .pin_in,
   .pin_out, .pin_oe, .bus_interrupt_input, .bus_dma_request,
   .bus_ready_input, .hi_func_in
);

`default_nettype wire

// ### testbench/pio_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module pio_pin_model
#(
   parameter logic [31:0] PULL = 32'h0F0F_00FF
)
(
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] ext_val,
   input wire logic [31:0] ext_en,
   output logic [31:0] pin_in
);
   // released pins fall to their termination level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & PULL);
endmodule

`default_nettype wire

// ### testbench/pio_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pio_defines.svh"

`define PIO_CHK(nm, e, g) \
   begin \
      checks++; \
      if ((g) !== (e)) \
      begin \
         bad_count++; \
         $display("[FAIL] %s exp %h got %h", nm, e, g); \
      end \
   end

module pio_port_tb_top;
   localparam logic [31:0] PULL = 32'h0F0F_00FF;
   logic core_clk, srst, req_valid, req_ack, req_busy;
   pio_pkg::pio_req_t req;
   logic [31:0] req_rdata, pin_in, pin_out, pin_oe, ext_val, ext_en;
   logic [3:0] dack, drq;
   logic tc, aen, bhe, ale, rdy;
   logic [10:8] irq;
   logic [15:0] hf_out, hf_oe, hf_in;
   logic [31:0] fs, dir, lvl, rd, e;
   logic [15:0] ao;
   int bad_count, checks;
   logic [11:0] offs [4] = '{`PIO_OFF_DIR_LO, `PIO_OFF_LVL_LO,
      `PIO_OFF_SET_LO, `PIO_OFF_CLR_LO};

   pio_port dut
   (
      .core_clk(core_clk), .srst(srst), .req_valid(req_valid), .req(req),
      .req_ack(req_ack), .req_busy(req_busy), .req_rdata(req_rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .bus_dma_acknowledge(dack), .bus_terminal_count(tc),
      .bus_address_enable(aen), .bus_byte_high_enable(bhe),
      .bus_address_latch_enable(ale), .bus_interrupt_input(irq),
      .bus_dma_request(drq), .bus_ready_input(rdy), .hi_func_out(hf_out),
      .hi_func_oe(hf_oe), .hi_func_in(hf_in)
   );

   pio_pin_model #(.PULL(PULL)) u_pins
   (
      .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
      .ext_en(ext_en), .pin_in(pin_in)
   );

   function automatic logic [31:0] ext_lvl();
      return (ext_en & ext_val) | (~ext_en & PULL);
   endfunction

   function automatic logic [31:0] exp_pins();
      return (dir & lvl) | (~dir & ext_lvl());
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // one access, entered at a falling edge, left one edge after the ack
   task automatic acc(input logic w, input logic s, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
      int n;
      req = {w, s, a, d};
      req_valid = 1'b1;
      @(negedge core_clk);
      req_valid = 1'b0;
      n = 0;
      while (req_ack !== 1'b1 && n < 4)
      begin
         @(negedge core_clk);
         n++;
      end
      r = req_rdata;
      if (n == 4)
      begin
         bad_count++;
         $display("[FAIL] ack exp 1 got 0");
         conclude();
      end
      @(negedge core_clk);
   endtask

   // k: 0 direction, 1 level, 2 drive high, 3 drive low
   task automatic put(input int k, input int h, input logic [15:0] d);
      logic [31:0] m, w, r;
      m = {16'h0, d} << (16 * h);
      w = ~fs & dir & (32'h0000_FFFF << (16 * h));
      case (k)
         0: dir = (dir & ~(~fs & (32'h0000_FFFF << (16 * h)))) | (m & ~fs);
         1: lvl = (lvl & ~w) | (m & w);
         2: lvl = lvl | (m & w);
         default: lvl = lvl & ~(m & w);
      endcase
      acc(1'b1, 1'b0, offs[k] + 12'(2 * h), {16'h0, d}, r);
   endtask

   task automatic rdlvl();
      logic [31:0] r, x;
      for (int h = 0; h < 2; h++)
      begin
         acc(1'b0, 1'b0, `PIO_OFF_LVL_LO + 12'(2 * h), 32'h0, r);
         x = (exp_pins() ^ (r << (16 * h))) & ~fs;
         `PIO_CHK("level", 16'h0, x[16*h+:16])
      end
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   initial
   begin
      srst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      void'($urandom(32'h279A_7BC6));
      ext_val = $urandom;
      ext_en = $urandom;
      {dack, tc, aen, bhe, ale} = 8'($urandom);
      hf_out = 16'($urandom);
      hf_oe = 16'($urandom);
      fs = 32'h0;
      dir = 32'h0;
      lvl = 32'h0;
      repeat (5) @(negedge core_clk);
      srst = 1'b0;
      `PIO_CHK("oe", 32'h0, pin_oe)
      acc(1'b0, 1'b1, `PIO_OFF_FS_LO, 32'h0, rd);
      `PIO_CHK("select", 32'h0, rd)
      for (int k = 0; k < 4; k++)
         for (int h = 0; h < 2; h++)
         begin
            acc(1'b0, 1'b0, offs[k] + 12'(2 * h), 32'h0, rd);
            e = (k == 1) ? exp_pins() >> (16 * h) : 32'h0;
            `PIO_CHK("reg", e[15:0], rd[15:0])
         end
      acc(1'b1, 1'b0, 12'hC24, 32'h0000_FFFF, rd);
      acc(1'b0, 1'b0, 12'hC24, 32'h0, rd);
      `PIO_CHK("unmapped", 32'h0, rd)
      for (int i = 0; i < 60; i++)
      begin
         ext_val = $urandom;
         ext_en = $urandom;
         {dack, tc, aen, bhe, ale} = 8'($urandom);
         put($urandom % 4, $urandom % 2, 16'($urandom));
         `PIO_CHK("oe", dir, pin_oe)
         `PIO_CHK("out", lvl & dir, pin_out & dir)
         rdlvl();
      end
      acc(1'b1, 1'b1, `PIO_OFF_FS_LO, 32'h8000_FFFF, rd);
      fs = 32'h8000_FFFF;
      acc(1'b0, 1'b1, `PIO_OFF_FS_LO, 32'h0, rd);
      `PIO_CHK("select", fs, rd)
      put(0, 0, 16'hFFFF);
      put(1, 0, 16'h0000);
      acc(1'b0, 1'b0, `PIO_OFF_DIR_LO, 32'h0, rd);
      `PIO_CHK("dir", dir[15:0], rd[15:0])
      repeat (2) @(negedge core_clk);
      e = ext_lvl();
      ao = {3'h0, dack[0], dack[1], dack[2], dack[3], 4'h0, tc, aen, 1'b0,
         bhe, ale};
      `PIO_CHK("routed oe", `PIO_ALT_DRIVE_LO, pin_oe[15:0])
      `PIO_CHK("routed out", ao, pin_out[15:0])
      `PIO_CHK("irq", {e[13], e[14], e[15]}, irq)
      `PIO_CHK("drq", {e[5], e[6], e[7], e[8]}, drq)
      `PIO_CHK("rdy", e[2], rdy)
      `PIO_CHK("hi oe", hf_oe[15], pin_oe[31])
      `PIO_CHK("hi in", hf_oe[15] ? hf_out[15] : e[31], hf_in[15])
      acc(1'b0, 1'b0, `PIO_OFF_LVL_LO, 32'h0, rd);
      `PIO_CHK("level", e[15], rd[15])
      rdlvl();
      conclude();
   end
endmodule

`default_nettype wire
